//--- logic/imb_pkg.sv
// Constants, carriers and modes of the host mailbox bridge.
// Assumes one 250 MHz clock and byte-wide register paths.
package imb_pkg;

	// ------------------------------------------------------------------
	// Register offsets on the host I/O side
	// ------------------------------------------------------------------
	localparam logic [11:0] IMB_ISA_DATA_ADDR  = 12'hCA9;
	localparam logic [11:0] IMB_ISA_CTRL_ADDR  = 12'hCAA;
	localparam logic [11:0] IMB_ISA_FLAGS_ADDR = 12'hCAB;
	localparam int          IMB_ISA_SEL_W      = 3;

	// ------------------------------------------------------------------
	// Register offsets on the microcontroller data space
	// ------------------------------------------------------------------
	localparam logic [15:0] IMB_MC_FLAGS_ADDR0 = 16'hFF00;
	localparam logic [15:0] IMB_MC_DATA_ADDR   = 16'hFF01;
	localparam logic [15:0] IMB_MC_CTRL_ADDR   = 16'hFF02;
	localparam logic [15:0] IMB_MC_FLAGS_ADDR1 = 16'hFF03;
	localparam logic [15:0] IMB_MC_FLAGS_ADDR2 = 16'hFF07;

	// ------------------------------------------------------------------
	// Flags register layout
	// ------------------------------------------------------------------
	localparam int          IMB_FLAG_RX_READY  = 7;
	localparam int          IMB_FLAG_TX_READY  = 6;
	localparam int          IMB_FLAG_HOST_SMI  = 4;
	localparam int          IMB_FLAG_SYSW_MSG  = 3;
	localparam int          IMB_FLAG_SYSW_AVL  = 2;
	localparam int          IMB_FLAG_BUSY      = 0;
	localparam logic [7:0]  IMB_FLAGS_MASK     = 8'hDD;
	localparam logic [7:0]  IMB_REG_RESET      = 8'h00;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int          IMB_FIFO_DEPTH     = 16;
	localparam int          IMB_SYNC_STAGES    = 2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		IMB_MODE_OFF  = 2'b00,
		IMB_MODE_RUN  = 2'b01,
		IMB_MODE_PROG = 2'b11
	} imb_mode_e;

	typedef struct packed {
		logic [IMB_ISA_SEL_W-1:0] sel;
		logic [7:0]               data;
	} imb_wr_s;

endpackage : imb_pkg

//--- logic/imb_bridge.sv
// Host mailbox bridge: host I/O side and microcontroller side share
// three byte registers, ownership steered by the busy flag.
// Assumes all input pins but clk_i and rst_n_i are asynchronous to clk_i and are synchronised here.

// ----------------------------------------------------------------------
// Write queue between host strobes and the register engine
// ----------------------------------------------------------------------
module imb_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             clear_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem[rd_ptr_reg];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (clear_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 :
					wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 :
					rd_ptr_reg + AW'(1);
			end
			if (push && !pop) begin
				count_reg <= count_reg + (AW+1)'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - (AW+1)'(1);
			end
		end
	end

endmodule : imb_fifo

// ----------------------------------------------------------------------
// Bridge top
// ----------------------------------------------------------------------
module imb_bridge #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        power_stable_i,
	input  wire logic        bus_reset_n_i,
	input  wire logic        front_panel_reset_i,
	input  wire logic [2:0]  isa_sa_i,
	input  wire logic [7:0]  isa_sd_i,
	output logic      [7:0]  isa_sd_o,
	output logic             isa_sd_oe_o,
	input  wire logic        isa_ior_n_i,
	input  wire logic        isa_iow_n_i,
	input  wire logic        isa_aen_i,
	input  wire logic        decode_chip_select_n_i,
	input  wire logic        aux_chip_select_n_i,
	output logic             isa_chrdy_o,
	input  wire logic [15:0] mc_addr_i,
	input  wire logic [7:0]  mc_data_i,
	output logic      [7:0]  mc_data_o,
	output logic             mc_data_oe_o,
	input  wire logic        mc_rd_n_i,
	input  wire logic        mc_wr_n_i,
	output logic             mgmt_mailbox_irq_n_o,
	output logic             system_powergood_ctrl_o,
	output logic             mgmt_reset_oc_n_o,
	output logic             mgmt_reset_oc_oe_o,
	output logic             functional_oe_o,
	input  wire logic        prog_chain_enable_n_i,
	input  wire logic        prog_serial_in_i,
	input  wire logic        prog_mode_sel_i,
	input  wire logic        prog_serial_clk_i,
	output logic             prog_serial_out_o,
	output logic             prog_serial_out_oe_o
);
	import imb_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	localparam int NB = 49;

	logic [NB-1:0] pins_async;
	logic [NB-1:0] sync1_reg;
	logic [NB-1:0] sync2_reg;

	assign pins_async = {power_stable_i, bus_reset_n_i, front_panel_reset_i,
		isa_sa_i, isa_sd_i, isa_ior_n_i, isa_iow_n_i, isa_aen_i,
		decode_chip_select_n_i, aux_chip_select_n_i, mc_addr_i, mc_data_i,
		mc_rd_n_i, mc_wr_n_i, prog_chain_enable_n_i, prog_serial_in_i,
		prog_mode_sel_i, prog_serial_clk_i};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= pins_async;
			sync2_reg <= sync1_reg;
		end
	end

	logic        pwr_s;
	logic        brst_n_s;
	logic        fpr_s;
	logic [2:0]  sa_s;
	logic [7:0]  sd_s;
	logic        ior_n_s;
	logic        iow_n_s;
	logic        aen_s;
	logic        pcs_n_s;
	logic        acs_n_s;
	logic [15:0] ma_s;
	logic [7:0]  md_s;
	logic        mrd_n_s;
	logic        mwr_n_s;
	logic        pen_n_s;
	logic        psi_s;
	logic        pmode_s;
	logic        pclk_s;

	assign {pwr_s, brst_n_s, fpr_s, sa_s, sd_s, ior_n_s, iow_n_s, aen_s,
		pcs_n_s, acs_n_s, ma_s, md_s, mrd_n_s, mwr_n_s, pen_n_s, psi_s,
		pmode_s, pclk_s} = sync2_reg;

	// ------------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------------
	imb_mode_e mode_reg;
	imb_mode_e mode_next;
	logic      clear;

	always_comb begin
		case (mode_reg)
			IMB_MODE_OFF:  mode_next = pwr_s ? IMB_MODE_RUN : IMB_MODE_OFF;
			IMB_MODE_RUN:  mode_next = !pwr_s ? IMB_MODE_OFF :
				(!pen_n_s ? IMB_MODE_PROG : IMB_MODE_RUN);
			IMB_MODE_PROG: mode_next = !pwr_s ? IMB_MODE_OFF :
				(pen_n_s ? IMB_MODE_RUN : IMB_MODE_PROG);
			default:       mode_next = IMB_MODE_OFF;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_reg <= IMB_MODE_OFF;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign clear = !pwr_s || !brst_n_s;

	// ------------------------------------------------------------------
	// Host strobes and selection
	// ------------------------------------------------------------------
	logic       isa_sel;
	logic       iow_n_d_reg;
	logic       ior_act;
	logic       isa_wr_pend_reg;
	imb_wr_s    isa_wr_reg;
	imb_wr_s    q_head;
	logic       q_in_ready;
	logic       q_out_valid;
	logic       q_pop;
	logic       isa_wr_end;

	assign isa_sel = (!pcs_n_s || !acs_n_s) && !aen_s;
	assign ior_act = isa_sel && !ior_n_s;
	assign isa_wr_end = iow_n_s && !iow_n_d_reg && isa_wr_pend_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			iow_n_d_reg     <= 1'b1;
			isa_wr_pend_reg <= 1'b0;
			isa_wr_reg      <= '0;
		end else begin
			iow_n_d_reg <= iow_n_s;
			if (isa_sel && !iow_n_s) begin
				isa_wr_pend_reg <= 1'b1;
				isa_wr_reg.sel  <= sa_s;
				isa_wr_reg.data <= sd_s;
			end else if (iow_n_s) begin
				isa_wr_pend_reg <= 1'b0;
			end
		end
	end

	imb_fifo #(
		.WIDTH ($bits(imb_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.clear_i     (clear),
		.in_valid_i  (isa_wr_end),
		.in_ready_o  (q_in_ready),
		.in_data_i   (isa_wr_reg),
		.out_valid_o (q_out_valid),
		.out_ready_i (q_pop),
		.out_data_o  (q_head)
	);

	// ------------------------------------------------------------------
	// Microcontroller strobes and decode
	// ------------------------------------------------------------------
	logic       mwr_n_d_reg;
	logic       mc_wr_pend_reg;
	logic [1:0] mc_wr_idx_reg;
	logic [7:0] mc_wr_data_reg;
	logic       mc_wr_end;
	logic [1:0] mc_idx;
	logic       mc_hit;

	always_comb begin
		mc_hit = 1'b1;
		case (ma_s)
			IMB_MC_DATA_ADDR:   mc_idx = 2'h1;
			IMB_MC_CTRL_ADDR:   mc_idx = 2'h2;
			IMB_MC_FLAGS_ADDR0: mc_idx = 2'h3;
			IMB_MC_FLAGS_ADDR1: mc_idx = 2'h3;
			IMB_MC_FLAGS_ADDR2: mc_idx = 2'h3;
			default: begin
				mc_idx = 2'h0;
				mc_hit = 1'b0;
			end
		endcase
	end

	assign mc_wr_end = mwr_n_s && !mwr_n_d_reg && mc_wr_pend_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mwr_n_d_reg    <= 1'b1;
			mc_wr_pend_reg <= 1'b0;
			mc_wr_idx_reg  <= 2'h0;
			mc_wr_data_reg <= 8'h00;
		end else begin
			mwr_n_d_reg <= mwr_n_s;
			if (mc_hit && !mwr_n_s) begin
				mc_wr_pend_reg <= 1'b1;
				mc_wr_idx_reg  <= mc_idx;
				mc_wr_data_reg <= md_s;
			end else if (mwr_n_s) begin
				mc_wr_pend_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Mailbox registers
	// ------------------------------------------------------------------
	logic [7:0] data_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] flags_reg;
	logic       busy;
	logic       run;

	assign busy  = flags_reg[IMB_FLAG_BUSY];
	assign run   = (mode_reg == IMB_MODE_RUN);
	// Queued host writes wait while a controller write lands
	assign q_pop = q_out_valid && !mc_wr_end;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_reg  <= IMB_REG_RESET;
			ctrl_reg  <= IMB_REG_RESET;
			flags_reg <= IMB_REG_RESET;
		end else if (clear) begin
			data_reg  <= IMB_REG_RESET;
			ctrl_reg  <= IMB_REG_RESET;
			flags_reg <= IMB_REG_RESET;
		end else if (mc_wr_end && busy && run) begin
			case (mc_wr_idx_reg)
				2'h1:    data_reg <= mc_wr_data_reg;
				2'h2:    ctrl_reg <= mc_wr_data_reg;
				2'h3:    flags_reg <= mc_wr_data_reg & IMB_FLAGS_MASK;
				default: data_reg <= data_reg;
			endcase
		end else if (q_pop && !busy && run) begin
			case (q_head.sel)
				IMB_ISA_DATA_ADDR[2:0]:  data_reg <= q_head.data;
				IMB_ISA_CTRL_ADDR[2:0]:  ctrl_reg <= q_head.data;
				IMB_ISA_FLAGS_ADDR[2:0]: begin
					flags_reg[IMB_FLAG_BUSY] <= q_head.data[IMB_FLAG_BUSY];
				end
				default: data_reg <= data_reg;
			endcase
		end
	end
	// Controller writes with busy clear fall through untouched
	// Host writes with busy set are popped and dropped
	// Busy is cleared again by the controller

	// ------------------------------------------------------------------
	// Read paths
	// ------------------------------------------------------------------
	logic [7:0] isa_rd;
	logic [7:0] mc_rd;
	logic       mc_rd_act;

	always_comb begin
		case (sa_s)
			IMB_ISA_DATA_ADDR[2:0]:  isa_rd = data_reg;
			IMB_ISA_CTRL_ADDR[2:0]:  isa_rd = ctrl_reg;
			IMB_ISA_FLAGS_ADDR[2:0]: isa_rd = flags_reg & IMB_FLAGS_MASK;
			default:                 isa_rd = 8'h00;
		endcase
		case (mc_idx)
			2'h1:    mc_rd = data_reg;
			2'h2:    mc_rd = ctrl_reg;
			2'h3:    mc_rd = flags_reg & IMB_FLAGS_MASK;
			default: mc_rd = 8'h00;
		endcase
	end

	assign mc_rd_act = mc_hit && !mrd_n_s;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			isa_sd_o     <= 8'h00;
			isa_sd_oe_o  <= 1'b0;
			mc_data_o    <= 8'h00;
			mc_data_oe_o <= 1'b0;
		end else begin
			isa_sd_o     <= pwr_s ? isa_rd : 8'h00;
			mc_data_o    <= pwr_s ? mc_rd : 8'h00;
			isa_sd_oe_o  <= ior_act && mode_reg != IMB_MODE_PROG;
			mc_data_oe_o <= mc_rd_act && mode_reg != IMB_MODE_PROG;
		end
	end

	// ------------------------------------------------------------------
	// Reset, interrupt and host-ready outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mgmt_mailbox_irq_n_o    <= 1'b1;
			system_powergood_ctrl_o <= 1'b0;
			mgmt_reset_oc_n_o       <= 1'b0;
			mgmt_reset_oc_oe_o      <= 1'b1;
			isa_chrdy_o             <= 1'b1;
			functional_oe_o         <= 1'b0;
		end else begin
			mgmt_mailbox_irq_n_o    <= ~busy;
			system_powergood_ctrl_o <= pwr_s && !fpr_s;
			mgmt_reset_oc_n_o       <= 1'b0;
			mgmt_reset_oc_oe_o      <= !pwr_s;
			isa_chrdy_o             <= q_in_ready;
			functional_oe_o         <= (mode_next != IMB_MODE_PROG);
		end
	end

	// ------------------------------------------------------------------
	// Programming chain pass-through
	// ------------------------------------------------------------------
	logic pclk_d_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pclk_d_reg           <= 1'b0;
			prog_serial_out_o    <= 1'b0;
			prog_serial_out_oe_o <= 1'b0;
		end else begin
			pclk_d_reg           <= pclk_s;
			prog_serial_out_oe_o <= (mode_next == IMB_MODE_PROG);
			if (pclk_s && !pclk_d_reg && pmode_s) begin
				prog_serial_out_o <= psi_s;
			end
		end
	end

endmodule : imb_bridge

//--- verif/imb_bridge_sva.sv
// Checker of the host mailbox bridge, seen from its top-level ports.
// Assumes a single clk_i domain and the asynchronous rst_n_i.
module imb_bridge_sva #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       power_stable_i,
	input wire logic       front_panel_reset_i,
	input wire logic       isa_iow_n_i,
	input wire logic       isa_ior_n_i,
	input wire logic [7:0] isa_sd_o,
	input wire logic       isa_sd_oe_o,
	input wire logic [7:0] mc_data_o,
	input wire logic       mc_data_oe_o,
	input wire logic       mgmt_mailbox_irq_n_o,
	input wire logic       system_powergood_ctrl_o,
	input wire logic       mgmt_reset_oc_n_o,
	input wire logic       mgmt_reset_oc_oe_o,
	input wire logic       functional_oe_o,
	input wire logic       prog_chain_enable_n_i,
	input wire logic       prog_serial_out_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ------------------------------------------------------------------
	// Cycles since the host write strobe was last low
	// ------------------------------------------------------------------
	logic [3:0] iow_age;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			iow_age <= 4'hF;
		else if (!isa_iow_n_i)
			iow_age <= 4'h0;
		else if (iow_age != 4'hF)
			iow_age <= iow_age + 4'h1;
	end
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	property p_busy_by_host;
		$fell(mgmt_mailbox_irq_n_o) |-> iow_age <= 4'h8;
	endproperty
	a_busy_by_host: assert property (p_busy_by_host)
		else $error("interrupt asserted without a host write");
	property p_sd_oe_read;
		isa_sd_oe_o |-> !$past(isa_ior_n_i, 3);
	endproperty
	a_sd_oe_read: assert property (p_sd_oe_read)
		else $error("host data driven outside a read");
	property p_prog_on;
		!prog_chain_enable_n_i [*6] |-> prog_serial_out_oe_o && !functional_oe_o;
	endproperty
	a_prog_on: assert property (p_prog_on)
		else $error("programming mode outputs wrong");
	property p_prog_off;
		prog_chain_enable_n_i [*6] |-> !prog_serial_out_oe_o;
	endproperty
	a_prog_off: assert property (p_prog_off)
		else $error("serial out driven outside programming");
	property p_front_reset;
		front_panel_reset_i [*6] |-> !system_powergood_ctrl_o;
	endproperty
	a_front_reset: assert property (p_front_reset)
		else $error("front-panel reset not holding system");
	property p_power_low;
		!power_stable_i [*6] |-> !system_powergood_ctrl_o && mgmt_reset_oc_oe_o;
	endproperty
	a_power_low: assert property (p_power_low)
		else $error("power low without resets held");
	property p_power_read0;
		!power_stable_i [*6] ##0 (isa_sd_oe_o || mc_data_oe_o)
			|-> isa_sd_o == 8'h00 && mc_data_o == 8'h00;
	endproperty
	a_power_read0: assert property (p_power_read0)
		else $error("nonzero read data while power low");
	property p_oc_level;
		mgmt_reset_oc_n_o == 1'b0;
	endproperty
	a_oc_level: assert property (p_oc_level)
		else $error("open-collector reset level not low");
	c_busy: cover property ($fell(mgmt_mailbox_irq_n_o));
	c_read: cover property ($rose(isa_sd_oe_o));
	c_prog: cover property ($rose(prog_serial_out_oe_o));
endmodule : imb_bridge_sva

bind imb_bridge imb_bridge_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.*);

//--- verif/imb_mc_model.sv
// Microcontroller model on the external data bus of the bridge.
// Assumes the bench calls its tasks; idle bus shows the inverted last value.
module imb_mc_model (
	input wire logic        clk_i,
	input wire logic [7:0]  dut_data_i,
	input wire logic        dut_oe_i,
	output logic     [15:0] mc_addr_o,
	output logic     [7:0]  mc_data_o,
	output logic            mc_rd_n_o,
	output logic            mc_wr_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] drv = 8'h00;
	logic       drv_en = 1'b0;
	initial begin
		mc_addr_o = 16'h0000;
		mc_rd_n_o = 1'b1;
		mc_wr_n_o = 1'b1;
	end
	assign mc_data_o = dut_oe_i ? dut_data_i : (drv_en ? drv : ~drv);
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic mc_wr(input logic [15:0] a, input logic [7:0] d);
		step(1);
		mc_addr_o = a;
		drv = d;
		drv_en = 1'b1;
		mc_wr_n_o = 1'b0;
		step(3);
		mc_wr_n_o = 1'b1;
		step(3);
		drv_en = 1'b0;
		step(3);
	endtask : mc_wr
	task automatic mc_rd(input logic [15:0] a, output logic [7:0] d);
		step(1);
		mc_addr_o = a;
		mc_rd_n_o = 1'b0;
		step(5);
		d = mc_data_o;
		mc_rd_n_o = 1'b1;
		step(4);
	endtask : mc_rd
endmodule : imb_mc_model

//--- verif/imb_bridge_tb.sv
// Self-checking bench of the host mailbox bridge.
// Assumes imb_pkg, imb_bridge, its checker and the controller model.
module imb_bridge_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import imb_pkg::*;
	logic clk_i = 0, rst_n_i = 0, pwr = 1, brst_n = 1, fpr = 0;
	logic [2:0]  sa = 0;
	logic [7:0]  hd = 0, sd_o, mdo, mdi, d;
	logic        hd_en = 0, ior_n = 1, iow_n = 1, aen = 0;
	logic        dcs_n = 1, acs_n = 1, sd_oe, mc_oe, chrdy, irq_n, pgc;
	logic        ocn, ocoe, foe, pen_n = 1, psi = 0, pms = 0, pck = 0;
	logic        pso, psoe, rd_n, wr_n;
	logic [15:0] ma;
	wire  [7:0]  sd = sd_oe ? sd_o : (hd_en ? hd : ~hd);
	int n_fail = 0, checked = 0, cyc = 0;
	initial forever #2 clk_i = ~clk_i;
	imb_bridge #(.FIFO_DEPTH(16)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.power_stable_i(pwr), .bus_reset_n_i(brst_n),
		.front_panel_reset_i(fpr), .isa_sa_i(sa), .isa_sd_i(sd),
		.isa_sd_o(sd_o), .isa_sd_oe_o(sd_oe), .isa_ior_n_i(ior_n),
		.isa_iow_n_i(iow_n), .isa_aen_i(aen), .decode_chip_select_n_i(dcs_n),
		.aux_chip_select_n_i(acs_n), .isa_chrdy_o(chrdy), .mc_addr_i(ma),
		.mc_data_i(mdi), .mc_data_o(mdo), .mc_data_oe_o(mc_oe),
		.mc_rd_n_i(rd_n), .mc_wr_n_i(wr_n), .mgmt_mailbox_irq_n_o(irq_n),
		.system_powergood_ctrl_o(pgc), .mgmt_reset_oc_n_o(ocn),
		.mgmt_reset_oc_oe_o(ocoe), .functional_oe_o(foe),
		.prog_chain_enable_n_i(pen_n), .prog_serial_in_i(psi),
		.prog_mode_sel_i(pms), .prog_serial_clk_i(pck),
		.prog_serial_out_o(pso), .prog_serial_out_oe_o(psoe));
	imb_mc_model mc (.clk_i(clk_i), .dut_data_i(mdo), .dut_oe_i(mc_oe),
		.mc_addr_o(ma), .mc_data_o(mdi), .mc_rd_n_o(rd_n),
		.mc_wr_n_o(wr_n));
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic conclude();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic isa_wr(input logic [2:0] a, input logic [7:0] v, input logic aux);
		for (int i = 0; i < 50 && chrdy !== 1'b1; i++)
			step(1);
		sa = a;
		hd = v;
		hd_en = 1;
		{acs_n, dcs_n} = aux ? 2'b01 : 2'b10;
		iow_n = 0;
		step(3);
		iow_n = 1;
		step(2);
		hd_en = 0;
		{acs_n, dcs_n} = 2'b11;
		step(6);
	endtask : isa_wr
	task automatic isa_rd(input logic [2:0] a, input logic aux, input logic [7:0] exp);
		sa = a;
		{acs_n, dcs_n} = aux ? 2'b01 : 2'b10;
		ior_n = 0;
		step(5);
		chk({7'h0, sd_oe}, 8'h01);
		chk(sd, exp);
		ior_n = 1;
		{acs_n, dcs_n} = 2'b11;
		step(5);
	endtask : isa_rd
	task automatic mc_chk(input logic [15:0] a, input logic [7:0] exp);
		mc.mc_rd(a, d);
		chk(d, exp);
	endtask : mc_chk
	// ------------------------------------------------------------------
	// Timeout
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		step(6);
		rst_n_i = 1;
		step(8);
		isa_rd(3'h3, 0, IMB_REG_RESET);
		chk({6'h0, irq_n, pgc}, 8'h03);
		chk({7'h0, chrdy}, 8'h01);
		isa_wr(3'h1, 8'hA5, 0);
		isa_wr(3'h2, 8'h3C, 1);
		mc.mc_wr(IMB_MC_DATA_ADDR, 8'h11);
		mc.mc_wr(IMB_MC_FLAGS_ADDR0, 8'hFF);
		isa_rd(3'h1, 1, 8'hA5);
		isa_rd(3'h2, 0, 8'h3C);
		mc_chk(IMB_MC_FLAGS_ADDR1, 8'h00);
		isa_wr(3'h3, 8'hFE, 0);
		isa_rd(3'h3, 0, 8'h00);
		isa_wr(3'h3, 8'hFF, 0);
		isa_rd(3'h3, 1, 8'h01);
		chk({7'h0, irq_n}, 8'h00);
		isa_wr(3'h1, 8'h77, 0);
		mc.mc_wr(IMB_MC_DATA_ADDR, 8'h5A);
		mc.mc_wr(IMB_MC_CTRL_ADDR, 8'hC3);
		mc.mc_wr(IMB_MC_FLAGS_ADDR2, 8'hFF);
		isa_rd(3'h1, 0, 8'h5A);
		isa_rd(3'h3, 0, 8'hDD);
		mc_chk(IMB_MC_FLAGS_ADDR0, 8'hDD);
		mc_chk(IMB_MC_FLAGS_ADDR2, 8'hDD);
		mc_chk(IMB_MC_CTRL_ADDR, 8'hC3);
		mc_chk(IMB_MC_DATA_ADDR, 8'h5A);
		mc.mc_wr(IMB_MC_FLAGS_ADDR1, 8'h80);
		mc_chk(IMB_MC_FLAGS_ADDR1, 8'h80);
		chk({7'h0, irq_n}, 8'h01);
		isa_rd(3'h0, 0, 8'h00);
		aen = 1;
		{dcs_n, ior_n} = 2'b00;
		step(6);
		chk({7'h0, sd_oe}, 8'h00);
		{aen, dcs_n, ior_n} = 3'b011;
		step(5);
		fpr = 1;
		step(8);
		chk({7'h0, pgc}, 8'h00);
		fpr = 0;
		step(8);
		chk({7'h0, pgc}, 8'h01);
		pwr = 0;
		step(8);
		chk({6'h0, pgc, ocoe}, 8'h01);
		isa_rd(3'h2, 0, 8'h00);
		pwr = 1;
		step(8);
		isa_rd(3'h2, 0, 8'h00);
		isa_rd(3'h1, 0, 8'h00);
		isa_wr(3'h1, 8'h24, 0);
		isa_rd(3'h1, 0, 8'h24);
		brst_n = 0;
		step(8);
		brst_n = 1;
		step(8);
		isa_rd(3'h1, 0, 8'h00);
		chk({6'h0, foe, psoe}, 8'h02);
		{pen_n, pms} = 2'b01;
		for (int i = 0; i < 2; i++) begin
			psi = ~psi;
			step(6);
			pck = 1;
			step(6);
			pck = 0;
			step(4);
			chk({5'h0, foe, psoe, pso}, {6'h01, psi});
		end
		{pen_n, pms} = 2'b10;
		step(8);
		chk({7'h0, psoe}, 8'h00);
		conclude();
	end
endmodule : imb_bridge_tb
